// ==== pkg/timer_defines.svh ====
// Purpose: offsets, field positions, reset values and timing counts of the dual timer
// Assumes: included by bare name; guarded against double inclusion
// Notes: register indices are byte addresses divided by four
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// register indices; byte address is four times the index
`define TMR_IDX_CTRL 8'h88
`define TMR_IDX_MODE 8'h89
`define TMR_IDX_T0_LO 8'h8A
`define TMR_IDX_T1_LO 8'h8B
`define TMR_IDX_T0_HI 8'h8C
`define TMR_IDX_T1_HI 8'h8D

// control register fields
`define TMR_CTRL_SECOND_FLAG 7
`define TMR_CTRL_SECOND_RUN 6
`define TMR_CTRL_FIRST_FLAG 5
`define TMR_CTRL_FIRST_RUN 4

// mode register fields
`define TMR_MODE_T0_LSB 0
`define TMR_MODE_T0_CNT 2
`define TMR_MODE_T1_LSB 4
`define TMR_MODE_T1_CNT 6
`define TMR_MODE_MASK 8'h77

// reset values
`define TMR_RST_CTRL 8'h00
`define TMR_RST_MODE 8'h00
`define TMR_RST_COUNT 8'h00

// machine cycle length in clock states, event spacing in cycles, mode 0 low-byte width in bits
`define TMR_STATES_PER_CYCLE 6
`define TMR_EVENTS_MIN_CYCLES 2
`define TMR_MODE0_LO_BITS 5

`endif

// ==== pkg/timer_pkg.sv ====
// Purpose: types shared by the dual timer files
// Assumes: timer_defines.svh on the include path
// Notes: bus signals travel as packed structs
`include "timer_defines.svh"
package timer_pkg;

  localparam int APB_AW = 12;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef enum logic [1:0] {
    MODE_13BIT = 2'h0,
    MODE_16BIT = 2'h1,
    MODE_8BIT_RELOAD = 2'h2,
    MODE_SPLIT = 2'h3
  } count_mode_t;

  typedef enum logic [5:0] {
    ST_S1 = 6'h01,
    ST_S2 = 6'h02,
    ST_S3 = 6'h04,
    ST_S4 = 6'h08,
    ST_S5 = 6'h10,
    ST_S6 = 6'h20
  } machine_state_t;

endpackage

// ==== testbench/dual_timer_event_counter_bench.sv ====
// Purpose: self-checking bench for the dual timer
// Assumes: zero-wait APB slave, pins idle high
// Notes: counts are read after run bits clear
`timescale 1ns/1ps
`include "timer_defines.svh"
module dual_timer_event_counter_bench;
  import timer_pkg::*;
  logic clk;
  logic rstn;
  apb_req_t req;
  apb_rsp_t rsp;
  logic p1, p2, pulse, f1, f2, go, busy;
  logic [7:0] edges;
  logic [4:0] hold;
  logic [7:0] ticks;
  logic [7:0] t0;
  int n_errors;
  int checks_done;
  dual_timer_event_counter uut (.i_clk_sys(clk), .i_rstn(rstn), .i_apb(req), .o_apb(rsp),
    .i_first_count_input_pin(p1), .i_second_count_input_pin(p2),
    .o_second_timer_overflow_pulse(pulse), .o_first_timer_overflow_flag(f1),
    .o_second_timer_overflow_flag(f2));
  event_source_model far (.i_clk_sys(clk), .i_rstn(rstn), .i_go(go), .i_edges(edges),
    .i_hold(hold), .i_tick(pulse), .o_first_pin(p1), .o_second_pin(p2), .o_busy(busy),
    .o_ticks(ticks));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic give_verdict;
    if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
      output logic [31:0] rd, output logic err);
    req <= '{1'b1, 1'b0, w, {2'h0, idx, 2'h0}, {24'h0, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic e;
    xfer(1'b1, idx, d, rd, e);
  endtask
  task automatic chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] rd;
    logic e;
    xfer(1'b0, idx, 8'h00, rd, e);
    cmp($sformatf("reg %h", idx), {24'h0, exp}, rd);
  endtask
  task automatic ovf(input logic [7:0] mode, input logic [7:0] lo_i, input logic [7:0] lo,
      input logic [7:0] hi, input logic [7:0] run);
    int k;
    k = 0;
    wr(`TMR_IDX_CTRL, 8'h00);
    wr(`TMR_IDX_MODE, mode);
    wr(lo_i, lo);
    wr(lo_i + 8'h02, hi);
    wr(`TMR_IDX_CTRL, run);
    while (({f2, f1} & {run[6], run[4]}) !== {run[6], run[4]} && k < 400) begin
      @(posedge clk);
      k++;
    end
    cmp("flags", {30'h0, run[6], run[4]}, {30'h0, f2 & run[6], f1 & run[4]});
    // stop counting but keep the flags, so the counts read back are final
    wr(`TMR_IDX_CTRL, {run[6], 1'b0, run[4], 5'h0});
  endtask
  task automatic burst(input logic [7:0] n, input logic [4:0] h);
    int k;
    k = 0;
    go <= 1'b1;
    edges <= n;
    hold <= h;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    while (busy !== 1'b0 && k < 400) begin
      @(posedge clk);
      k++;
    end
    repeat (12) @(posedge clk);
  endtask
  initial begin
    logic [31:0] rd;
    logic e;
    rstn = 1'b0;
    req = '0;
    go = 1'b0;
    edges = 8'h00;
    hold = 5'h06;
    n_errors = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    cmp("outputs", 32'h0, {29'h0, pulse, f1, f2});
    for (int i = `TMR_IDX_CTRL; i <= `TMR_IDX_T1_HI; i++) chk(8'(i), 8'h00);
    xfer(1'b0, 8'h8E, 8'h00, rd, e);
    cmp("unmapped", 32'h1, {31'h0, e});
    wr(`TMR_IDX_MODE, 8'hFF);
    chk(`TMR_IDX_MODE, `TMR_MODE_MASK);
    wr(`TMR_IDX_CTRL, 8'h0F);
    chk(`TMR_IDX_CTRL, 8'h00);
    ovf(8'h01, `TMR_IDX_T0_LO, 8'hFE, 8'hFF, 8'h10);
    chk(`TMR_IDX_T0_HI, 8'h00);
    repeat (20) @(posedge clk);
    chk(`TMR_IDX_T0_LO, 8'h00);
    wr(`TMR_IDX_CTRL, 8'h00);
    cmp("first flag", 32'h0, {31'h0, f1});
    t0 = ticks;
    ovf(8'h00, `TMR_IDX_T1_LO, 8'hFF, 8'hFF, 8'h40);
    chk(`TMR_IDX_T1_LO, 8'hE0);
    ovf(8'h20, `TMR_IDX_T1_LO, 8'hFE, 8'hA0, 8'h40);
    chk(`TMR_IDX_T1_LO, 8'hA0);
    cmp("ticks", {24'h0, t0 + 8'h02}, {24'h0, ticks});
    wr(`TMR_IDX_T1_LO, 8'hFF);
    wr(`TMR_IDX_T1_HI, 8'hFF);
    wr(`TMR_IDX_CTRL, 8'h40);
    repeat (12) @(posedge clk);
    t0 = ticks;
    repeat (60) @(posedge clk);
    cmp("tick rate", {24'h0, t0 + 8'h0A}, {24'h0, ticks});
    wr(`TMR_IDX_CTRL, 8'h00);
    wr(`TMR_IDX_MODE, 8'h55);
    wr(`TMR_IDX_T0_LO, 8'h00);
    wr(`TMR_IDX_T1_LO, 8'h00);
    wr(`TMR_IDX_CTRL, 8'h50);
    burst(8'h05, 5'h06);
    burst(8'h03, 5'h0C);
    wr(`TMR_IDX_CTRL, 8'h00);
    chk(`TMR_IDX_T0_LO, 8'h08);
    chk(`TMR_IDX_T1_LO, 8'h08);
    wr(`TMR_IDX_T1_LO, 8'h55);
    ovf(8'h33, `TMR_IDX_T0_LO, 8'hFF, 8'hFF, 8'h50);
    chk(`TMR_IDX_T1_LO, 8'h55);
    chk(`TMR_IDX_T0_HI, 8'h00);
    chk(`TMR_IDX_T0_LO, 8'h00);
    ovf(8'h02, `TMR_IDX_T0_LO, 8'hFF, 8'h5A, 8'h10);
    chk(`TMR_IDX_T0_LO, 8'h5A);
    ovf(8'h00, `TMR_IDX_T0_LO, 8'hFF, 8'hFF, 8'h10);
    chk(`TMR_IDX_T0_LO, 8'hE0);
    chk(`TMR_IDX_T0_HI, 8'h00);
    // split first timer: the second one runs without its run bit and sets no flag
    wr(`TMR_IDX_CTRL, 8'h00);
    wr(`TMR_IDX_T1_LO, 8'hFF);
    wr(`TMR_IDX_T1_HI, 8'hFF);
    wr(`TMR_IDX_MODE, 8'h23);
    repeat (12) @(posedge clk);
    t0 = ticks;
    repeat (60) @(posedge clk);
    cmp("split baud ticks", {24'h0, t0 + 8'h0A}, {24'h0, ticks});
    cmp("split flags", 32'h0, {30'h0, f2, f1});
    // reset in mid-run clears every register and output
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    cmp("outputs after reset", 32'h0, {29'h0, pulse, f1, f2});
    chk(`TMR_IDX_MODE, 8'h00);
    chk(`TMR_IDX_T1_LO, 8'h00);
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
endmodule

// ==== testbench/event_source_model.sv ====
// Purpose: far side: count pin bursts and baud tick counter
// Assumes: pins idle high between bursts
// Notes: each level held i_hold clocks
`timescale 1ns/1ps
module event_source_model (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_go,
  input wire logic [7:0] i_edges,
  input wire logic [4:0] i_hold,
  input wire logic i_tick,
  output logic o_first_pin,
  output logic o_second_pin,
  output logic o_busy,
  output logic [7:0] o_ticks
);
  import timer_pkg::*;
  logic [8:0] half_r;
  logic [4:0] wait_r;
  logic level_r;
  assign o_first_pin = level_r;
  assign o_second_pin = level_r;
  assign o_busy = half_r != 9'h0;
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      half_r <= 9'h0;
      wait_r <= 5'h0;
      level_r <= 1'b1;
    end else if (i_go) begin
      half_r <= {i_edges, 1'b0};
      wait_r <= i_hold;
    end else if (o_busy && wait_r > 5'h1) begin
      wait_r <= wait_r - 5'h1;
    end else if (o_busy) begin
      wait_r <= i_hold;
      half_r <= half_r - 9'h1;
      level_r <= ~level_r;
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ticks <= 8'h0;
    end else if (i_tick) begin
      o_ticks <= o_ticks + 8'h1;
    end
  end
endmodule

// ==== testbench/timer_chk_assertions.sv ====
// Purpose: port checks for the dual timer
// Assumes: bound to the top module
// Notes: flags are judged only against bus writes
`timescale 1ns/1ps
module timer_chk (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire timer_pkg::apb_req_t i_apb,
  input wire timer_pkg::apb_rsp_t o_apb,
  input wire logic i_first_count_input_pin,
  input wire logic i_second_count_input_pin,
  input wire logic o_second_timer_overflow_pulse,
  input wire logic o_first_timer_overflow_flag,
  input wire logic o_second_timer_overflow_flag
);
  import timer_pkg::*;
  logic acc;
  logic wr_ctrl;
  assign acc = i_apb.psel && i_apb.penable;
  assign wr_ctrl = acc && i_apb.pwrite && i_apb.paddr == 12'h220;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);
  sequence setup_s;
    i_apb.psel && !i_apb.penable;
  endsequence
  sequence ctrl_wr_s;
    wr_ctrl;
  endsequence
  a_ready_zero_wait: assert property (setup_s ##1 acc |-> o_apb.pready)
    else $error("pready low in access");
  a_err_range: assert property (acc && (i_apb.paddr < 12'h220 || i_apb.paddr > 12'h237)
    |-> o_apb.pslverr) else $error("unmapped access not refused");
  a_ok_mapped: assert property (wr_ctrl |-> !o_apb.pslverr)
    else $error("mapped access refused");
  a_rdata_upper: assert property (acc |-> o_apb.prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_pulse_spacing: assert property (o_second_timer_overflow_pulse |=>
    !o_second_timer_overflow_pulse [*5]) else $error("pulses closer than a machine cycle");
  a_flag1_hold: assert property ($fell(o_first_timer_overflow_flag) |-> $past(wr_ctrl))
    else $error("first flag dropped without write");
  a_flag2_hold: assert property ($fell(o_second_timer_overflow_flag) |-> $past(wr_ctrl))
    else $error("second flag dropped without write");
  a_flag1_write: assert property (ctrl_wr_s ##0 i_apb.pwdata[5] |=>
    o_first_timer_overflow_flag) else $error("first flag write lost");
  a_flag2_write: assert property (ctrl_wr_s ##0 i_apb.pwdata[7] |=>
    o_second_timer_overflow_flag) else $error("second flag write lost");
endmodule

bind dual_timer_event_counter timer_chk u_chk (
  .i_clk_sys(i_clk_sys),
  .i_rstn(i_rstn),
  .i_apb(i_apb),
  .o_apb(o_apb),
  .i_first_count_input_pin(i_first_count_input_pin),
  .i_second_count_input_pin(i_second_count_input_pin),
  .o_second_timer_overflow_pulse(o_second_timer_overflow_pulse),
  .o_first_timer_overflow_flag(o_first_timer_overflow_flag),
  .o_second_timer_overflow_flag(o_second_timer_overflow_flag)
);

// ==== verilog/count_input_sampler.sv ====
// Purpose: samples one external count input once per machine cycle
// Assumes: i_sample pulses in state S5, i_consume in state S3
// Notes: event stays pending until consumed at the next S3
`timescale 1ns/1ps
module count_input_sampler (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_pin,
  input wire logic i_sample,
  input wire logic i_consume,
  output logic o_event
);

  logic last_r;
  logic pend_r;

  // last sample starts low so a low pin after reset is no event
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      last_r <= 1'b0;
    end else if (i_sample) begin
      last_r <= i_pin;
    end
  end

  // one sample high then the next low marks a falling transition
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      pend_r <= 1'b0;
    end else if (i_sample && last_r && !i_pin) begin
      pend_r <= 1'b1;
    end else if (i_consume) begin
      pend_r <= 1'b0;
    end
  end

  assign o_event = pend_r;

endmodule

// ==== verilog/dual_timer_event_counter.sv ====
// Purpose: two timer/event counters with four modes, reached over APB
// Assumes: count pins synchronous to i_clk_sys; APB slave with no wait states
// Notes: all counting happens in state S3 of the six-state machine cycle
`timescale 1ns/1ps
`include "timer_defines.svh"
module dual_timer_event_counter (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input timer_pkg::apb_req_t i_apb,
  output timer_pkg::apb_rsp_t o_apb,
  // first count input is the pin shared with the secure interface clock
  input wire logic i_first_count_input_pin,
  input wire logic i_second_count_input_pin,
  output logic o_second_timer_overflow_pulse,
  output logic o_first_timer_overflow_flag,
  output logic o_second_timer_overflow_flag
);
  import timer_pkg::*;

  machine_state_t state_r;
  machine_state_t state_nxt;
  logic [7:0] ctrl_r;
  logic [7:0] mode_r;
  logic [7:0] t0_lo_r;
  logic [7:0] t0_hi_r;
  logic [7:0] t1_lo_r;
  logic [7:0] t1_hi_r;
  logic [31:0] prdata_r;
  // counting strobes; tick and sample are high during one state of the machine cycle, ev0 and ev1 from S6 through S3
  logic tick;
  logic sample;
  logic ev0;
  logic ev1;
  logic [7:0] idx;
  logic addr_hit;
  logic wr_en;
  logic setup;
  count_mode_t m0;
  count_mode_t m1;
  logic cnt0_sel;
  logic cnt1_sel;
  logic inc0;
  logic inc0_hi;
  logic inc1;
  logic run1;
  // {overflow, high byte, low byte} of the incremented count
  logic [16:0] step0;
  logic [16:0] step1;
  logic [8:0] step0_hi;
  logic ovf0;
  logic ovf1;
  logic ovf0_hi;
  logic set_flag0;
  logic set_flag1;

  // returns {overflow, high byte, low byte} after one count
  // mode 0 leaves low bits 7..5 alone, so software may park data there
  function automatic logic [16:0] count_step(input count_mode_t mode, input logic [7:0] hi,
                                             input logic [7:0] lo);
    logic [13:0] c13;
    logic [16:0] c16;
    logic [8:0] c8;
    c13 = 14'h0000;
    c16 = 17'h00000;
    c8 = 9'h000;
    case (mode)
      MODE_13BIT: begin
        c13 = {1'b0, hi, lo[`TMR_MODE0_LO_BITS-1:0]} + 14'h0001;
        count_step = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
      end
      MODE_16BIT: begin
        c16 = {1'b0, hi, lo} + 17'h00001;
        count_step = c16;
      end
      MODE_8BIT_RELOAD: begin
        c8 = {1'b0, lo} + 9'h001;
        count_step = c8[8] ? {1'b1, hi, hi} : {1'b0, hi, c8[7:0]};
      end
      MODE_SPLIT: begin
        c8 = {1'b0, lo} + 9'h001;
        count_step = {c8[8], hi, c8[7:0]};
      end
      default: begin
        count_step = {1'b0, hi, lo};
      end
    endcase
  endfunction

  // both timers key off this one sequencer, so their counts stay in step
  // machine cycle sequencer, one state per clock
  always_comb begin
    case (state_r)
      ST_S1: state_nxt = ST_S2;
      ST_S2: state_nxt = ST_S3;
      ST_S3: state_nxt = ST_S4;
      ST_S4: state_nxt = ST_S5;
      ST_S5: state_nxt = ST_S6;
      ST_S6: state_nxt = ST_S1;
      default: state_nxt = ST_S1;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= ST_S1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign tick = (state_r == ST_S3);
  assign sample = (state_r == ST_S5);

  // an event waits in its sampler until the next S3, four clocks later
  // falling edge detectors
  count_input_sampler u_sample0 (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_pin(i_first_count_input_pin),
    .i_sample(sample),
    .i_consume(tick),
    .o_event(ev0)
  );

  count_input_sampler u_sample1 (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_pin(i_second_count_input_pin),
    .i_sample(sample),
    .i_consume(tick),
    .o_event(ev1)
  );

  assign m0 = count_mode_t'(mode_r[`TMR_MODE_T0_LSB+1:`TMR_MODE_T0_LSB]);
  assign m1 = count_mode_t'(mode_r[`TMR_MODE_T1_LSB+1:`TMR_MODE_T1_LSB]);
  assign cnt0_sel = mode_r[`TMR_MODE_T0_CNT];
  assign cnt1_sel = mode_r[`TMR_MODE_T1_CNT];

  // at most one event per two cycles
  assign inc0 = tick &&
                ctrl_r[`TMR_CTRL_FIRST_RUN] &&
                (cnt0_sel ? ev0 : 1'b1);
  // split high half uses second run bit
  assign inc0_hi = tick && (m0 == MODE_SPLIT) && ctrl_r[`TMR_CTRL_SECOND_RUN];
  // while the first timer is split its high half owns the second run bit,
  // so the second timer keeps running for baud generation
  assign run1 = (m0 == MODE_SPLIT) ? 1'b1 : ctrl_r[`TMR_CTRL_SECOND_RUN];
  // no split mode for second timer
  assign inc1 = tick &&
                run1 &&
                (m1 != MODE_SPLIT) &&
                (cnt1_sel ? ev1 : 1'b1);

  // overflow is judged on the count before the increment lands
  assign step0 = count_step(m0, t0_hi_r, t0_lo_r);
  assign step1 = count_step(m1, t1_hi_r, t1_lo_r);
  assign step0_hi = {1'b0, t0_hi_r} + 9'h001;
  assign ovf0 = inc0 && step0[16];
  assign ovf1 = inc1 && step1[16];
  assign ovf0_hi = inc0_hi && step0_hi[8];

  assign set_flag0 = ovf0;
  assign set_flag1 = (m0 == MODE_SPLIT) ? ovf0_hi : ovf1;

  // APB decode; pready is always high so every access takes two cycles
  assign idx = i_apb.paddr[9:2];
  assign addr_hit = (i_apb.paddr[1:0] == 2'h0) && (i_apb.paddr[timer_pkg::APB_AW-1:10] == 2'h0) &&
                    (idx >= `TMR_IDX_CTRL) && (idx <= `TMR_IDX_T1_HI);
  assign setup = i_apb.psel && !i_apb.penable;
  assign wr_en = i_apb.psel && i_apb.penable && i_apb.pwrite && addr_hit;

  // control: software writes; a hardware set in the same edge wins
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_r <= `TMR_RST_CTRL;
    end else begin
      // bits 3..0 are reserved: writes are dropped, reads give zero
      if (wr_en && idx == `TMR_IDX_CTRL) begin
        ctrl_r <= {i_apb.pwdata[7:4], 4'h0};
      end
      if (set_flag0) begin
        ctrl_r[`TMR_CTRL_FIRST_FLAG] <= 1'b1;
      end
      if (set_flag1) begin
        ctrl_r[`TMR_CTRL_SECOND_FLAG] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_r <= `TMR_RST_MODE;
    end else if (wr_en && idx == `TMR_IDX_MODE) begin
      // reserved mode bits are masked so they always read back zero
      mode_r <= i_apb.pwdata[7:0] & `TMR_MODE_MASK;
    end
  end

  // first timer; a software write overrides the hardware update
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      t0_lo_r <= `TMR_RST_COUNT;
    end else if (wr_en && idx == `TMR_IDX_T0_LO) begin
      t0_lo_r <= i_apb.pwdata[7:0];
    end else if (inc0) begin
      t0_lo_r <= step0[7:0];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      t0_hi_r <= `TMR_RST_COUNT;
    end else if (wr_en && idx == `TMR_IDX_T0_HI) begin
      t0_hi_r <= i_apb.pwdata[7:0];
    end else if (inc0_hi) begin
      t0_hi_r <= step0_hi[7:0];
    end else if (inc0 && m0 != MODE_SPLIT) begin
      t0_hi_r <= step0[15:8];
    end
  end

  // second timer; a software write overrides the hardware update
  // while the first timer is split, its overflow only makes the baud tick
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      t1_lo_r <= `TMR_RST_COUNT;
    end else if (wr_en && idx == `TMR_IDX_T1_LO) begin
      t1_lo_r <= i_apb.pwdata[7:0];
    end else if (inc1) begin
      t1_lo_r <= step1[7:0];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      t1_hi_r <= `TMR_RST_COUNT;
    end else if (wr_en && idx == `TMR_IDX_T1_HI) begin
      t1_hi_r <= i_apb.pwdata[7:0];
    end else if (inc1) begin
      t1_hi_r <= step1[15:8];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_second_timer_overflow_pulse <= 1'b0;
    end else begin
      o_second_timer_overflow_pulse <= ovf1;
    end
  end

  // a 16-bit count is read a byte at a time and may roll over in between
  // read data captured in the setup cycle, stable through the access phase
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup) begin
      prdata_r <= 32'h0000_0000;
      if (addr_hit && !i_apb.pwrite) begin
        case (idx)
          `TMR_IDX_CTRL: prdata_r[7:0] <= ctrl_r;
          `TMR_IDX_MODE: prdata_r[7:0] <= mode_r;
          `TMR_IDX_T0_LO: prdata_r[7:0] <= t0_lo_r;
          `TMR_IDX_T1_LO: prdata_r[7:0] <= t1_lo_r;
          `TMR_IDX_T0_HI: prdata_r[7:0] <= t0_hi_r;
          `TMR_IDX_T1_HI: prdata_r[7:0] <= t1_hi_r;
          default: prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign o_apb.pready = 1'b1;
  // unmapped or misaligned addresses answer with an error, no effect
  assign o_apb.pslverr = i_apb.psel && i_apb.penable && !addr_hit;
  assign o_apb.prdata = prdata_r;
  assign o_first_timer_overflow_flag = ctrl_r[`TMR_CTRL_FIRST_FLAG];
  assign o_second_timer_overflow_flag = ctrl_r[`TMR_CTRL_SECOND_FLAG];

endmodule
